// >>> lsm_top.sv
/*
  Light sensor measurement sequencer with APB register file and
  open-drain threshold alarm.
  Assumes: osc_in is the free running conversion oscillator from a pin,
  vis_pulse and ir_pulse are charge-balance pulses of the two photodiode
  converters, all asynchronous to pclk and slower than pclk / 4.
*/
//
// Summary of operation
// - Start powered down, no conversion uncommanded
// - Result reads zero until first conversion
// - One-shot converts once then powers down
// - Continuous mode repeats, overwriting result
// - Power-down command stops conversion, not a pending one-shot
// - Internal timing counts oscillator, n selectable
// - External timing: period between two marks
// - Visible and infrared channel selections
// - Result unsigned, resolution wide, max 16
// - Alarm active low, open drain
// - Alarm when above high or below low
// - Conversions continue while alarm asserted
// - Persistence filters short excursions
// - Host selects full-scale span, first most sensitive
// - Operation code 000 off, 101 visible, 110 IR
// - Persistence codes need 1,4,8,16 conversions
// - Alarm held until first command register read
// - Resolution sets 65536/4096/256/16 cycles
`timescale 1ns/1ps
`include "lsm_cfg.svh"

module lsm_top
  import lsm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_in,
  input  wire logic        vis_pulse,
  input  wire logic        ir_pulse,
  output logic             integ_active,
  output logic             chan_ir_sel,
  output logic      [1:0]  full_scale_span,
  output logic             alarm_n_out,
  output logic             alarm_n_oe
);

  // ========================================================================
  // Input synchronisers and edge detection
  logic [2:0] pin_s;
  logic [2:0] pin_d_r;
  logic       osc_rise;
  logic       vis_rise;
  logic       ir_rise;

  lsm_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ir_pulse, vis_pulse, osc_in}),
    .q       (pin_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 3'b000;
    end else begin
      pin_d_r <= pin_s;
    end
  end

  assign osc_rise = pin_s[0] & ~pin_d_r[0];
  assign vis_rise = pin_s[1] & ~pin_d_r[1];
  assign ir_rise  = pin_s[2] & ~pin_d_r[2];

  // ========================================================================
  // APB decode
  logic [3:0] idx;
  logic       mapped;
  logic       acc;
  logic       wr_acc;
  logic       rd_setup;

  assign idx      = paddr[5:2];
  assign mapped   = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00)
                    && (idx <= `LSM_IDX_LAST);
  assign acc      = psel & penable;
  assign wr_acc   = acc & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;

  // ========================================================================
  // Configuration registers
  logic [2:0]  op_r;
  logic [1:0]  persist_r;
  logic [1:0]  res_r;
  logic [1:0]  span_r;
  logic [15:0] thr_lo_r;
  logic [15:0] thr_hi_r;
  logic        ext_en_r;
  logic [2:0]  op_nxt;
  logic [1:0]  persist_nxt;
  logic [1:0]  res_nxt;
  logic [1:0]  span_nxt;
  logic [15:0] thr_lo_nxt;
  logic [15:0] thr_hi_nxt;
  logic        ext_en_nxt;
  logic        shot_req;
  logic        shot_ir_req;
  logic        ext_mark;
  logic        off_cmd;

  always_comb begin
    op_nxt      = op_r;
    persist_nxt = persist_r;
    res_nxt     = res_r;
    span_nxt    = span_r;
    thr_lo_nxt  = thr_lo_r;
    thr_hi_nxt  = thr_hi_r;
    ext_en_nxt  = ext_en_r;
    shot_req    = 1'b0;
    shot_ir_req = 1'b0;
    ext_mark    = 1'b0;
    off_cmd     = 1'b0;
    if (wr_acc) begin
      case (idx)
        `LSM_IDX_CMD1: begin
          op_nxt      = pwdata[`LSM_OP_MSB:`LSM_OP_LSB];
          persist_nxt = pwdata[`LSM_PRST_MSB:`LSM_PRST_LSB];
          off_cmd     = (pwdata[`LSM_OP_MSB:`LSM_OP_LSB] == LSM_OP_OFF);
        end
        `LSM_IDX_CMD2: begin
          res_nxt  = pwdata[`LSM_RES_MSB:`LSM_RES_LSB];
          span_nxt = pwdata[`LSM_SPAN_MSB:`LSM_SPAN_LSB];
        end
        `LSM_IDX_LT_LO: thr_lo_nxt[7:0]  = pwdata[7:0];
        `LSM_IDX_LT_HI: thr_lo_nxt[15:8] = pwdata[7:0];
        `LSM_IDX_HT_LO: thr_hi_nxt[7:0]  = pwdata[7:0];
        `LSM_IDX_HT_HI: thr_hi_nxt[15:8] = pwdata[7:0];
        `LSM_IDX_CTRL: begin
          ext_en_nxt  = pwdata[`LSM_CTRL_EXT_EN];
          shot_req    = pwdata[`LSM_CTRL_ONESHOT];
          shot_ir_req = pwdata[`LSM_CTRL_SHOT_IR];
          ext_mark    = pwdata[`LSM_CTRL_EXT_MARK];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r      <= 3'(`LSM_RST_CMD1 >> `LSM_OP_LSB);
      persist_r <= 2'b00;
      res_r     <= 2'b00;
      span_r    <= 2'b00;
      thr_lo_r  <= `LSM_RST_LT;
      thr_hi_r  <= `LSM_RST_HT;
      ext_en_r  <= 1'b0;
    end else begin
      op_r      <= op_nxt;
      persist_r <= persist_nxt;
      res_r     <= res_nxt;
      span_r    <= span_nxt;
      thr_lo_r  <= thr_lo_nxt;
      thr_hi_r  <= thr_hi_nxt;
      ext_en_r  <= ext_en_nxt;
    end
  end

  // ========================================================================
  // Conversion sequencer
  lsm_state_t  state_r;
  lsm_state_t  state_nxt;
  logic [16:0] cyc_r;
  logic [16:0] cyc_nxt;
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;
  logic        shot_r;
  logic        shot_nxt;
  logic        ir_r;
  logic        ir_nxt;
  logic        conv_done;
  logic        cont_mode;
  logic        want;
  logic        end_int;
  logic        pulse_sel;
  logic [16:0] cyc_lim;
  logic [15:0] res_max;

  // Only 101 and 110 run continuously
  assign cont_mode = (op_r == LSM_OP_VIS) || (op_r == LSM_OP_IR);
  assign want      = cont_mode || shot_r;
  assign pulse_sel = ir_r ? ir_rise : vis_rise;

  always_comb begin
    case (res_r)
      2'b00:   begin cyc_lim = `LSM_OSC_CYC_16; res_max = `LSM_MAX_16; end
      2'b01:   begin cyc_lim = `LSM_OSC_CYC_12; res_max = `LSM_MAX_12; end
      2'b10:   begin cyc_lim = `LSM_OSC_CYC_8;  res_max = `LSM_MAX_8;  end
      default: begin cyc_lim = `LSM_OSC_CYC_4;  res_max = `LSM_MAX_4;  end
    endcase
  end

  // Internal: oscillator count; external: second mark
  assign end_int = ext_en_r ? ext_mark
                            : (osc_rise && (cyc_r == cyc_lim - 17'h00001));

  always_comb begin
    state_nxt = state_r;
    cyc_nxt   = cyc_r;
    acc_nxt   = acc_r;
    data_nxt  = data_r;
    shot_nxt  = shot_r | shot_req;
    ir_nxt    = ir_r;
    conv_done = 1'b0;
    case (state_r)
      LSM_ST_OFF: begin
        cyc_nxt = 17'h00000;
        acc_nxt = 16'h0000;
        if (cont_mode || shot_req) begin
          ir_nxt    = shot_req ? shot_ir_req : (op_r == LSM_OP_IR);
          state_nxt = ext_en_nxt ? LSM_ST_ARM : LSM_ST_INTEG;
        end
      end
      LSM_ST_ARM: begin
        if (off_cmd && !shot_r) begin
          state_nxt = LSM_ST_OFF;
        end else if (ext_mark) begin
          state_nxt = LSM_ST_INTEG;
        end
      end
      LSM_ST_INTEG: begin
        if (osc_rise) begin
          cyc_nxt = cyc_r + 17'h00001;
        end
        // Unsigned count, saturates at n-bit full scale
        if (pulse_sel && (acc_r < res_max)) begin
          acc_nxt = acc_r + 16'h0001;
        end
        if (off_cmd && !shot_r) begin
          state_nxt = LSM_ST_OFF;
        end else if (end_int) begin
          conv_done = 1'b1;
          // Newest result overwrites, alarm or not
          data_nxt  = acc_nxt;
          cyc_nxt   = 17'h00000;
          acc_nxt   = 16'h0000;
          if (shot_r) begin
            shot_nxt  = shot_req;
            state_nxt = LSM_ST_OFF;
          end else if (!cont_mode) begin
            state_nxt = LSM_ST_OFF;
          end else begin
            ir_nxt    = (op_r == LSM_OP_IR);
            state_nxt = LSM_ST_INTEG;
          end
        end
      end
      default: begin
        state_nxt = LSM_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LSM_ST_OFF;
      cyc_r   <= 17'h00000;
      acc_r   <= 16'h0000;
      data_r  <= `LSM_RST_DATA;
      shot_r  <= 1'b0;
      ir_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
      acc_r   <= acc_nxt;
      data_r  <= data_nxt;
      shot_r  <= shot_nxt;
      ir_r    <= ir_nxt;
    end
  end

  // ========================================================================
  // Alarm flag
  logic trip;
  logic flag_r;
  logic flag_nxt;
  logic flag_rd;

  lsm_window u_window (
    .pclk        (pclk),
    .presetn     (presetn),
    .conv_done   (conv_done),
    .restart     (state_r == LSM_ST_OFF),
    .data        (data_nxt),
    .thr_lo      (thr_lo_r),
    .thr_hi      (thr_hi_r),
    .persist_sel (persist_r),
    .trip        (trip)
  );

  assign flag_rd = acc & ~pwrite & mapped & (idx == `LSM_IDX_CMD1);

  // Held until command read completes; a new trip wins
  always_comb begin
    flag_nxt = flag_r;
    if (flag_rd) begin
      flag_nxt = 1'b0;
    end
    if (trip) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign alarm_n_out = 1'b0;
  assign alarm_n_oe  = flag_r;

  // ========================================================================
  // Read data, captured in the setup phase
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;

  always_comb begin
    rd_nxt = 32'h00000000;
    case (idx)
      `LSM_IDX_CMD1:    rd_nxt[7:0] = {op_r, 2'b00, flag_r, persist_r};
      `LSM_IDX_CMD2:    rd_nxt[7:0] = {4'h0, res_r, span_r};
      `LSM_IDX_DATA_LO: rd_nxt[7:0] = data_r[7:0];
      `LSM_IDX_DATA_HI: rd_nxt[7:0] = data_r[15:8];
      `LSM_IDX_LT_LO:   rd_nxt[7:0] = thr_lo_r[7:0];
      `LSM_IDX_LT_HI:   rd_nxt[7:0] = thr_lo_r[15:8];
      `LSM_IDX_HT_LO:   rd_nxt[7:0] = thr_hi_r[7:0];
      `LSM_IDX_HT_HI:   rd_nxt[7:0] = thr_hi_r[15:8];
      `LSM_IDX_CTRL:    rd_nxt[7:0] = {5'h00, ext_en_r, 2'b00};
      `LSM_IDX_STAT:    rd_nxt[7:0] = {4'h0, ir_r, shot_r, state_r};
      default:          rd_nxt      = 32'h00000000;
    endcase
    if (!mapped) begin
      rd_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign integ_active    = (state_r == LSM_ST_INTEG);
  assign chan_ir_sel     = ir_r;
  assign full_scale_span = span_r;

endmodule

// >>> lsm_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the light
  sensor measurement block. Assumes it is included once per file by name.
*/
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define LSM_IDX_CMD1      4'h0
`define LSM_IDX_CMD2      4'h1
`define LSM_IDX_DATA_LO   4'h2
`define LSM_IDX_DATA_HI   4'h3
`define LSM_IDX_LT_LO     4'h4
`define LSM_IDX_LT_HI     4'h5
`define LSM_IDX_HT_LO     4'h6
`define LSM_IDX_HT_HI     4'h7
`define LSM_IDX_CTRL      4'h8
`define LSM_IDX_STAT      4'h9
`define LSM_IDX_LAST      4'h9

// ==========================================================================
// Field positions
`define LSM_OP_MSB        7
`define LSM_OP_LSB        5
`define LSM_FLAG_BIT      2
`define LSM_PRST_MSB      1
`define LSM_PRST_LSB      0
`define LSM_RES_MSB       3
`define LSM_RES_LSB       2
`define LSM_SPAN_MSB      1
`define LSM_SPAN_LSB      0
`define LSM_CTRL_ONESHOT  0
`define LSM_CTRL_SHOT_IR  1
`define LSM_CTRL_EXT_EN   2
`define LSM_CTRL_EXT_MARK 3

// ==========================================================================
// Reset values
`define LSM_RST_CMD1      8'h00
`define LSM_RST_CMD2      8'h00
`define LSM_RST_DATA      16'h0000
`define LSM_RST_LT        16'h0000
`define LSM_RST_HT        16'hFFFF

// ==========================================================================
// Oscillator cycles per conversion and result ceilings per resolution
`define LSM_OSC_CYC_16    17'h10000
`define LSM_OSC_CYC_12    17'h01000
`define LSM_OSC_CYC_8     17'h00100
`define LSM_OSC_CYC_4     17'h00010
`define LSM_MAX_16        16'hFFFF
`define LSM_MAX_12        16'h0FFF
`define LSM_MAX_8         16'h00FF
`define LSM_MAX_4         16'h000F

// Consecutive out-of-window conversions needed per persistence code
`define LSM_PERSIST_0     5'h01
`define LSM_PERSIST_1     5'h04
`define LSM_PERSIST_2     5'h08
`define LSM_PERSIST_3     5'h10

`endif

// >>> lsm_pkg.sv
/*
  Types of the light sensor measurement block.
  Assumes lsm_cfg.svh holds all numeric constants.
*/
package lsm_pkg;

  // ========================================================================
  // Operation codes
  typedef enum logic [2:0] {
    LSM_OP_OFF = 3'b000,
    LSM_OP_VIS = 3'b101,
    LSM_OP_IR  = 3'b110
  } lsm_op_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    LSM_ST_OFF   = 2'b00,
    LSM_ST_ARM   = 2'b01,
    LSM_ST_INTEG = 2'b10
  } lsm_state_t;

endpackage

// >>> lsm_sync.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level or pulse longer than two pclk periods.
*/
`timescale 1ns/1ps

module lsm_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// >>> lsm_window.sv
/*
  Threshold window check with persistence filter.
  Assumes conv_done is a one-cycle pulse with data valid in that cycle.
*/
`timescale 1ns/1ps
`include "lsm_cfg.svh"

module lsm_window
  import lsm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_done,
  input  wire logic        restart,
  input  wire logic [15:0] data,
  input  wire logic [15:0] thr_lo,
  input  wire logic [15:0] thr_hi,
  input  wire logic [1:0]  persist_sel,
  output logic             trip
);

  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic [4:0] need;
  logic [4:0] run_inc;
  logic       outside;

  always_comb begin
    case (persist_sel)
      2'b00:   need = `LSM_PERSIST_0;
      2'b01:   need = `LSM_PERSIST_1;
      2'b10:   need = `LSM_PERSIST_2;
      default: need = `LSM_PERSIST_3;
    endcase
  end

  assign outside = (data > thr_hi) || (data < thr_lo);
  // Saturate so a long excursion cannot wrap back under the need
  assign run_inc = (run_r == 5'h1F) ? run_r : run_r + 5'h01;

  always_comb begin
    run_nxt = run_r;
    trip    = 1'b0;
    if (restart) begin
      run_nxt = 5'h00;
    end else if (conv_done) begin
      if (outside) begin
        run_nxt = run_inc;
        trip    = (run_inc >= need);
      end else begin
        run_nxt = 5'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 5'h00;
    end else begin
      run_r <= run_nxt;
    end
  end

endmodule

// >>> lsm_top_asserts.sv
/*
  Port checker of lsm_top, bound to every instance of it.
  Assumes one pclk domain reset by presetn.
*/
`timescale 1ns/1ps

module lsm_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        integ_active,
  input wire logic        chan_ir_sel,
  input wire logic [1:0]  full_scale_span,
  input wire logic        alarm_n_out,
  input wire logic        alarm_n_oe
);
  // ========================
  // Helpers
  wire acc    = psel && penable;
  wire cmd_wr = acc && pwrite && (paddr == 12'h000 || paddr == 12'h020);
  wire cmd_rd = acc && !pwrite && paddr == 12'h000;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_cmd1_wr;
    acc && pwrite && paddr == 12'h000;
  endsequence
  sequence s_run_op;
    s_cmd1_wr ##0 (pwdata[7:5] == 3'h5 || pwdata[7:5] == 3'h6);
  endsequence
  sequence s_stop_op;
    s_cmd1_wr ##0 !(pwdata[7:5] == 3'h5 || pwdata[7:5] == 3'h6);
  endsequence
  // ========================
  // Properties
  bus_ready_a: assert property (acc |-> pready && (pwrite || prdata[31:8] == 24'h0))
    else $error("access not ready or upper read bits set");
  bad_addr_a: assert property (acc && paddr[11:6] != 6'h00 |-> pslverr)
    else $error("unmapped access without error");
  od_level_a: assert property (alarm_n_out == 1'b0)
    else $error("alarm pin driven high");
  span_upd_a: assert property (acc && pwrite && paddr == 12'h004
    |=> full_scale_span == $past(pwdata[1:0])) else $error("span not taken from write");
  run_start_a: assert property (s_run_op |-> ##[1:3] integ_active)
    else $error("run command did not start conversion");
  ir_chan_a: assert property (s_cmd1_wr ##0 pwdata[7:5] == 3'h6
    |-> ##[1:3] chan_ir_sel) else $error("infrared channel not selected");
  off_stop_a: assert property (s_stop_op |-> ##[1:3] !integ_active)
    else $error("conversion kept running after stop code");
  cmd_only_a: assert property ($rose(integ_active)
    |-> $past(cmd_wr) || $past(cmd_wr, 2) || $past(cmd_wr, 3))
    else $error("conversion started without a command");
  flag_hold_a: assert property (alarm_n_oe && !cmd_rd |=> alarm_n_oe)
    else $error("alarm released without command read");
  flag_clr_a: assert property (cmd_rd && alarm_n_oe |=> !alarm_n_oe)
    else $error("alarm not cleared by command read");
endmodule

bind lsm_top lsm_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .integ_active, .chan_ir_sel, .full_scale_span,
  .alarm_n_out, .alarm_n_oe);

// >>> lsm_front_model.sv
/*
  Front end model: conversion oscillator, photodiode pulses, alarm pin.
  Assumes the bench switches visible light with vis_on.
*/
`timescale 1ns/1ps

module lsm_front_model (
  input  wire logic vis_on,
  input  wire logic alarm_n_out,
  input  wire logic alarm_n_oe,
  output logic      osc_in,
  output logic      vis_pulse,
  output logic      ir_pulse,
  output logic      alarm_pin
);
  // ========================
  // Sources
  // Oscillator free runs, own phase, 125 ns period
  initial begin
    osc_in = 1'b0;
    #3.7;
    forever #62.5 osc_in = ~osc_in;
  end
  // Bright infrared every 60 ns so any oscillator-timed result saturates
  initial begin
    ir_pulse = 1'b0;
    forever #30 ir_pulse = ~ir_pulse;
  end
  // Visible every 250 ns while lit, none in the dark
  initial begin
    vis_pulse = 1'b0;
    forever #125 vis_pulse = vis_on & ~vis_pulse;
  end
  // ========================
  // Pin
  // Released pin rests on pull-up
  assign alarm_pin = (alarm_n_oe === 1'b1) ? alarm_n_out : 1'b1;
endmodule

// >>> lsm_top_tb_top.sv
/*
  Self-checking bench of lsm_top driven over APB.
  Assumes lsm_front_model supplies oscillator, light pulses and pull-up.
*/
`timescale 1ns/1ps
`include "lsm_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end

module lsm_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, vis_on, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic        pready, pslverr, osc_in, vis_pulse, ir_pulse, integ_active;
  logic        chan_ir_sel, alarm_n_out, alarm_n_oe, alarm_pin;
  logic [1:0]  full_scale_span;
  int          err_total, n_tests, cyc;
  logic [1:0]  res_c [3] = '{2'h3, 2'h2, 2'h1};
  int          osc_n [3] = '{`LSM_OSC_CYC_4, `LSM_OSC_CYC_8, `LSM_OSC_CYC_12};
  logic [15:0] top_v [3] = '{`LSM_MAX_4, `LSM_MAX_8, `LSM_MAX_12};
  logic [2:0]  bad_op [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

  lsm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_in, .vis_pulse, .ir_pulse, .integ_active, .chan_ir_sel,
    .full_scale_span, .alarm_n_out, .alarm_n_oe);
  lsm_front_model u_front (.vis_on, .alarm_n_out, .alarm_n_oe, .osc_in, .vis_pulse,
    .ir_pulse, .alarm_pin);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ========================
  // Bus tasks
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb_xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Bounded wait for a conversion edge, counting cycles
  task automatic wait_lvl(input logic lvl, input int lim);
    cyc = 0;
    while (integ_active !== lvl && cyc < lim) begin
      @(posedge pclk);
      cyc++;
    end
    `CHK(integ_active, lvl)
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  // ========================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, vis_on} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(integ_active, 1'b0)
    rchk(12'h000, 32'h0);
    rchk(12'h008, 32'h0);
    rchk(12'h00C, 32'h0);
    rchk(12'h018, 32'hFF);
    rchk(12'h01C, 32'hFF);
    rchk(12'h028, 32'h0);
    `CHK(slv, 1'b1)
    for (int s = 0; s < 4; s++) begin
      wr(12'h004, 8'h0C | 8'(s));
      @(negedge pclk);
      `CHK(full_scale_span, 2'(s))
    end
    // One-shot infrared at three resolutions; bright light saturates
    for (int i = 0; i < 3; i++) begin
      wr(12'h004, {4'h0, res_c[i], 2'h0});
      wr(12'h020, 8'h03);
      wait_lvl(1'b1, 40);
      wait_lvl(1'b0, 60000);
      `CHK((cyc - osc_n[i] * 25 / 2) inside {[-15 : 6]}, 1'b1)
      rchk(12'h008, {24'h0, top_v[i][7:0]});
      rchk(12'h00C, {24'h0, top_v[i][15:8]});
      apb_xfer(1'b0, 12'h024, 32'h0);
      `CHK(rd[2:0], 3'h0)
    end
    wr(12'h004, 8'h0C);
    vis_on <= 1'b1;
    wr(12'h000, 8'hA0);
    repeat (300) @(posedge pclk);
    `CHK(chan_ir_sel, 1'b0)
    apb_xfer(1'b0, 12'h008, 32'h0);
    `CHK(rd inside {[32'h6 : 32'h9]}, 1'b1)
    vis_on <= 1'b0;
    repeat (350) @(posedge pclk);
    rchk(12'h008, 32'h0);
    `CHK(alarm_pin, 1'b1)
    wr(12'h010, 8'h01);
    repeat (250) @(posedge pclk);
    `CHK(alarm_pin, 1'b0)
    wr(12'h010, 8'h00);
    repeat (250) @(posedge pclk);
    `CHK(alarm_pin, 1'b0)
    rchk(12'h000, 32'hA4);
    @(negedge pclk);
    `CHK(alarm_pin, 1'b1)
    `CHK(integ_active, 1'b1)
    // Infrared above the high limit needs 4, 8 and 16 conversions of 200 cycles
    wr(12'h000, 8'h00);
    wr(12'h018, 8'h0E);
    wr(12'h01C, 8'h00);
    for (int p = 1; p < 4; p++) begin
      wr(12'h000, 8'hC0 | 8'(p));
      repeat (200 * (2 << p) - 100) @(posedge pclk);
      `CHK(alarm_pin, 1'b1)
      `CHK(chan_ir_sel, 1'b1)
      repeat (200) @(posedge pclk);
      `CHK(alarm_pin, 1'b0)
      wr(12'h000, 8'h00);
      repeat (4) @(posedge pclk);
      `CHK(integ_active, 1'b0)
      rchk(12'h000, 32'h04);
      @(negedge pclk);
      `CHK(alarm_pin, 1'b1)
    end
    foreach (bad_op[j]) begin
      wr(12'h000, {bad_op[j], 5'h00});
      repeat (5) @(posedge pclk);
      `CHK(integ_active, 1'b0)
    end
    // Host-timed one-shot: two marks about 430 ns apart
    wr(12'h020, 8'h07);
    apb_xfer(1'b0, 12'h024, 32'h0);
    `CHK(rd[3:0], 4'hD)
    wr(12'h020, 8'h0C);
    repeat (40) @(posedge pclk);
    `CHK(integ_active, 1'b1)
    wr(12'h020, 8'h0C);
    repeat (4) @(posedge pclk);
    `CHK(integ_active, 1'b0)
    apb_xfer(1'b0, 12'h008, 32'h0);
    `CHK(rd inside {[32'h5 : 32'h9]}, 1'b1)
    wr(12'h020, 8'h00);
    report_and_stop();
  end
endmodule
